// [rtl/tdap_pkg.sv]
package tdap_pkg;

  // clock and delayed query after power-on
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned QUERY_DELAY_US  = 100;
  localparam int unsigned QUERY_DELAY_CYC = QUERY_DELAY_US * (CLK_HZ / 1_000_000);

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_SEAS_OFS   = 8'h04;
  localparam logic [7:0] ADDR_ONCE       = 8'h08;
  localparam logic [7:0] ADDR_REC_START  = 8'h0c;
  localparam logic [7:0] ADDR_REC_END    = 8'h10;
  localparam logic [7:0] ADDR_LEAP_TIME  = 8'h14;
  localparam logic [7:0] ADDR_ATOMIC_OFS = 8'h18;
  localparam logic [7:0] ADDR_STATUS     = 8'h1c;
  localparam logic [7:0] ADDR_PROG_PRE   = 8'h20;
  localparam logic [7:0] ADDR_PROG_ALARM = 8'h24;
  localparam logic [7:0] ADDR_PROG_COUNT = 8'h28;
  localparam logic [7:0] ADDR_UTC_TIME   = 8'h2c;
  localparam logic [7:0] ADDR_ZONE_OFS   = 8'h30;

  // control register bits
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_DEFER      = 2;
  localparam int CTRL_LEAP_POS   = 3;
  localparam int CTRL_LEAP_SET   = 4;
  localparam int CTRL_QRESTART   = 5;
  localparam int CTRL_ANNOUNCE   = 6;
  localparam int CTRL_ALARM_EN   = 7;
  localparam int CTRL_PROG_RST   = 8;
  localparam int CTRL_SRC_LSB    = 9;
  localparam int CTRL_QUERY      = 11;

  // status register bits
  localparam int STAT_TRUSTED    = 0;
  localparam int STAT_ANNOUNCE   = 1;
  localparam int STAT_SEAS_ACT   = 2;
  localparam int STAT_LEAP_PEND  = 3;
  localparam int STAT_LEAP_POS   = 4;
  localparam int STAT_LEAP_ARMED = 5;
  localparam int STAT_QUERY_REQ  = 6;
  localparam int STAT_ALARM      = 7;

  // time and date field layout shared by the time registers
  localparam int F_SEC_LSB   = 0;
  localparam int F_MIN_LSB   = 8;
  localparam int F_HOUR_LSB  = 16;
  localparam int F_DAY_LSB   = 0;
  localparam int F_WDAY_LSB  = 0;
  localparam int F_ORD_LSB   = 4;
  localparam int F_MONTH_LSB = 24;
  localparam int F_SIGN_BIT  = 15;
  localparam int OFS_HOUR_LSB = 8;

  // writable masks
  localparam logic [31:0] MASK_OFS  = 32'h0000_9f3f;
  localparam logic [31:0] MASK_ONCE = 32'h0f1f_3f1f;
  localparam logic [31:0] MASK_RULE = 32'h0f1f_3f77;
  localparam logic [31:0] MASK_HM   = 32'h001f_3f00;
  localparam logic [31:0] MASK_HMS  = 32'h001f_3f3f;

  // reset values and calendar constants
  localparam logic [7:0]  ATOMIC_OFS_RST = 8'h25;
  localparam logic [5:0]  SEC_SKIP       = 6'h3a;
  localparam logic [5:0]  SEC_LAST       = 6'h3b;
  localparam logic [5:0]  SEC_LEAP       = 6'h3c;
  localparam logic [5:0]  MIN_LAST       = 6'h3b;
  localparam logic [4:0]  HOUR_LAST      = 5'h17;
  localparam logic [2:0]  ORD_LAST       = 3'h7;
  localparam logic [13:0] MIN_PER_HOUR   = 14'h003c;
  localparam logic [13:0] MIN_PER_DAY    = 14'h05a0;

  typedef enum logic [1:0] {SEAS_DISABLED, SEAS_ONCE, SEAS_RECURRING, SEAS_RSVD} tdap_mode_t;
  typedef enum logic [1:0] {SRC_INTERNAL, SRC_TIMECODE, SRC_SATELLITE, SRC_NET_FOLLOWER}
    tdap_src_t;
  typedef enum logic [2:0] {LOG_NONE, LOG_SEAS_START, LOG_SEAS_END, LOG_LEAP, LOG_ALARM}
    tdap_log_t;

endpackage : tdap_pkg

// [rtl/tdap_adjust.sv]
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module tdap_adjust
  import tdap_pkg::*;
#(
  parameter int unsigned QUERY_DELAY    = tdap_pkg::QUERY_DELAY_CYC,
  parameter bit          QRESTART_RESET = 1'b1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  input  wire logic        sec_tick,
  input  wire logic [3:0]  cal_month,
  input  wire logic [4:0]  cal_day,
  input  wire logic [2:0]  cal_weekday,
  input  wire logic [4:0]  cal_month_days,
  input  wire logic        ext_leap_pending,
  input  wire logic        ext_leap_positive,
  input  wire logic        prog_reset_api,
  input  wire logic        prog_reset_gpi,
  input  wire logic        query_done,
  input  wire logic [7:0]  query_offset,
  output var  logic [16:0] utc_hms,
  output var  logic [10:0] local_minute,
  output var  logic [16:0] prog_hms,
  output var  logic [7:0]  atomic_time_offset_seconds,
  output var  logic        ptp_offset_valid,
  output var  logic        query_req,
  output var  logic        log_valid,
  output var  logic [2:0]  log_code,
  output var  logic        gpo_alarm
);

  if (QUERY_DELAY < 1) begin : g_chk
    $error("QUERY_DELAY must be at least one cycle");
  end

  typedef struct packed {
    logic              gpi_s1;
    logic              gpi_s2;
    logic              gpi_prev;
    logic              ap_wr;
    logic              rd_pend;
    logic [7:0]        ap_addr;
    logic              hreadyout;
    logic [31:0]       hrdata;
    tdap_mode_t        mode;
    tdap_src_t         src;
    logic              defer;
    logic              qrestart;
    logic              announce;
    logic              alarm_en;
    logic [31:0]       seas_ofs_w;
    logic [31:0]       once_w;
    logic [31:0]       rstart_w;
    logic [31:0]       rend_w;
    logic [31:0]       leap_w;
    logic [31:0]       zone_w;
    logic [31:0]       pre_w;
    logic [31:0]       alarm_w;
    logic [7:0]        atomic;
    logic              trusted;
    logic              leap_pend;
    logic              leap_pos;
    logic              leap_armed;
    logic              seas_active;
    logic signed [13:0] seas_min;
    logic [10:0]       chk_mod;
    logic [4:0]        uh;
    logic [5:0]        um;
    logic [5:0]        us;
    logic [4:0]        ph;
    logic [5:0]        pm;
    logic [5:0]        ps;
    logic [31:0]       qcnt;
    logic              boot_done;
    logic              query_req;
    logic              log_valid;
    tdap_log_t         log_code;
    logic              gpo_alarm;
    logic [10:0]       local_mod;
  } tdap_state_t;

  tdap_state_t st_reg;
  tdap_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic signed [13:0] ofs_minutes(input logic [31:0] w);
    logic [13:0] mag;
    mag = 14'(w[OFS_HOUR_LSB +: 5]) * MIN_PER_HOUR + 14'(w[F_MIN_LSB - 8 +: 6]);
    return w[F_SIGN_BIT] ? -$signed(mag) : $signed(mag);
  endfunction : ofs_minutes

  function automatic logic [10:0] hm_minutes(input logic [31:0] w);
    return 11'(14'(w[F_HOUR_LSB +: 5]) * MIN_PER_HOUR + 14'(w[F_MIN_LSB +: 6]));
  endfunction : hm_minutes

  // weekday, ordinal and month of a recurring rule against today
  function automatic logic rule_day(input logic [31:0] w, input logic [3:0] mon,
                                    input logic [4:0] day, input logic [2:0] wday,
                                    input logic [4:0] mdays);
    logic [2:0] week;
    logic       ord_ok;
    week = (day <= 5'h07) ? 3'h1 : (day <= 5'h0e) ? 3'h2 : (day <= 5'h15) ? 3'h3 :
           (day <= 5'h1c) ? 3'h4 : 3'h5;
    if (w[F_ORD_LSB +: 3] == ORD_LAST) begin
      ord_ok = (6'(day) + 6'h07) > 6'(mdays);
    end else begin
      ord_ok = (w[F_ORD_LSB +: 3] == week);
    end
    return ord_ok && (w[F_MONTH_LSB +: 4] == mon) && (w[F_WDAY_LSB +: 3] == wday);
  endfunction : rule_day

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic signed [13:0] t;
    logic [10:0]        utc_mod;
    logic               manual_src;
    logic               follow_src;
    logic               leap_here;
    logic               leap_done;
    logic               midnight;
    logic               prog_rst;
    logic               alarm_hit;
    logic [31:0]        rd;
    logic [31:0]        wd;
    st_next    = st_reg;
    t          = '0;
    rd         = '0;
    wd         = hwdata;
    leap_done  = 1'b0;
    midnight   = 1'b0;
    utc_mod    = '0;
    leap_here  = 1'b0;
    prog_rst   = 1'b0;
    alarm_hit  = 1'b0;
    manual_src = (st_reg.src == SRC_INTERNAL) || (st_reg.src == SRC_TIMECODE);
    follow_src = !manual_src;
    st_next.log_valid = 1'b0;
    st_next.hreadyout = 1'b1;

    st_next.gpi_s1   = prog_reset_gpi;
    st_next.gpi_s2   = st_reg.gpi_s1;
    st_next.gpi_prev = st_reg.gpi_s2;

    // local time: utc plus zone plus seasonal offset, wrapped into one day
    utc_mod = 11'(14'(st_reg.uh) * MIN_PER_HOUR + 14'(st_reg.um));
    t = $signed({3'b000, utc_mod}) + ofs_minutes(st_reg.zone_w) + st_reg.seas_min;
    if (t < 0) t = t + $signed(MIN_PER_DAY);
    if (t < 0) t = t + $signed(MIN_PER_DAY);
    if (t >= $signed(MIN_PER_DAY)) t = t - $signed(MIN_PER_DAY);
    if (t >= $signed(MIN_PER_DAY)) t = t - $signed(MIN_PER_DAY);
    st_next.local_mod = 11'(t);

    // leap minute: last utc minute of the day, or the deferred local minute
    if (st_reg.defer && follow_src) begin
      leap_here = st_reg.leap_armed && (st_next.local_mod == hm_minutes(st_reg.leap_w));
    end else begin
      leap_here = st_reg.leap_pend && (st_reg.uh == HOUR_LAST) && (st_reg.um == MIN_LAST);
    end

    // utc time of day with leap second handling
    if (sec_tick) begin
      if (leap_here && st_reg.leap_pos && (st_reg.us == SEC_LAST)) begin
        st_next.us = SEC_LEAP;
      end else if ((st_reg.us >= SEC_LAST) ||
                   (leap_here && !st_reg.leap_pos && (st_reg.us == SEC_SKIP))) begin
        st_next.us = '0;
        leap_done  = leap_here;
        if (st_reg.um == MIN_LAST) begin
          st_next.um = '0;
          if (st_reg.uh == HOUR_LAST) begin
            st_next.uh = '0;
            midnight   = 1'b1;
          end else begin
            st_next.uh = st_reg.uh + 5'h01;
          end
        end else begin
          st_next.um = st_reg.um + 6'h01;
        end
      end else begin
        st_next.us = st_reg.us + 6'h01;
      end
    end

    // deferral window opens at utc midnight, so it ends within a day
    if (midnight && st_reg.leap_pend && st_reg.defer && follow_src) begin
      st_next.leap_armed = 1'b1;
    end
    if (leap_done) begin
      st_next.atomic     = st_reg.leap_pos ? st_reg.atomic + 8'h01 : st_reg.atomic - 8'h01;
      st_next.leap_pend  = 1'b0;
      st_next.leap_armed = 1'b0;
      st_next.log_valid  = 1'b1;
      st_next.log_code   = LOG_LEAP;
    end

    // seasonal schedule, once per new local minute
    if (st_next.local_mod != st_reg.chk_mod) begin
      st_next.chk_mod = st_next.local_mod;
      if (st_reg.mode == SEAS_ONCE && cal_month == st_reg.once_w[F_MONTH_LSB +: 4] &&
          cal_day == st_reg.once_w[F_DAY_LSB +: 5] &&
          st_next.local_mod == hm_minutes(st_reg.once_w)) begin
        st_next.seas_min  = st_reg.seas_min + ofs_minutes(st_reg.seas_ofs_w);
        st_next.mode      = SEAS_DISABLED;
        st_next.log_valid = 1'b1;
        st_next.log_code  = LOG_SEAS_START;
      end else if (st_reg.mode == SEAS_RECURRING && !st_reg.seas_active &&
                   rule_day(st_reg.rstart_w, cal_month, cal_day, cal_weekday, cal_month_days) &&
                   st_next.local_mod == hm_minutes(st_reg.rstart_w)) begin
        st_next.seas_min    = ofs_minutes(st_reg.seas_ofs_w);
        st_next.seas_active = 1'b1;
        st_next.log_valid   = 1'b1;
        st_next.log_code    = LOG_SEAS_START;
      end else if (st_reg.mode == SEAS_RECURRING && st_reg.seas_active &&
                   rule_day(st_reg.rend_w, cal_month, cal_day, cal_weekday, cal_month_days) &&
                   st_next.local_mod == hm_minutes(st_reg.rend_w)) begin
        st_next.seas_min    = '0;
        st_next.seas_active = 1'b0;
        st_next.log_valid   = 1'b1;
        st_next.log_code    = LOG_SEAS_END;
      end
    end

    // program time counter
    prog_rst = prog_reset_api || (st_reg.gpi_s2 && !st_reg.gpi_prev) ||
               (st_reg.ap_wr && st_reg.ap_addr == ADDR_CTRL && wd[CTRL_PROG_RST]);
    if (prog_rst) begin
      st_next.ph = st_reg.pre_w[F_HOUR_LSB +: 5];
      st_next.pm = st_reg.pre_w[F_MIN_LSB +: 6];
      st_next.ps = st_reg.pre_w[F_SEC_LSB +: 6];
    end else if (sec_tick) begin
      if (st_reg.ps == SEC_LAST) begin
        st_next.ps = '0;
        if (st_reg.pm == MIN_LAST) begin
          st_next.pm = '0;
          st_next.ph = (st_reg.ph == HOUR_LAST) ? 5'h00 : st_reg.ph + 5'h01;
        end else begin
          st_next.pm = st_reg.pm + 6'h01;
        end
      end else begin
        st_next.ps = st_reg.ps + 6'h01;
      end
    end
    alarm_hit = st_reg.alarm_en &&
                ({st_reg.ph, st_reg.pm, st_reg.ps} ==
                 {st_reg.alarm_w[F_HOUR_LSB +: 5], st_reg.alarm_w[F_MIN_LSB +: 6],
                  st_reg.alarm_w[F_SEC_LSB +: 6]});
    st_next.gpo_alarm = alarm_hit;
    if (alarm_hit && !st_reg.gpo_alarm && !st_next.log_valid) begin
      st_next.log_valid = 1'b1;
      st_next.log_code  = LOG_ALARM;
    end

    // remote offset query, issued once after the power-on delay if qrestart is set and the source is internal or timecode
    if (!st_reg.boot_done) begin
      st_next.qcnt = st_reg.qcnt + 32'h1;
      if (st_reg.qcnt == 32'(QUERY_DELAY - 1)) begin
        st_next.boot_done = 1'b1;
        if (st_reg.qrestart && manual_src) st_next.query_req = 1'b1;
      end
    end
    if (query_done && st_reg.query_req) begin
      st_next.query_req = 1'b0;
      st_next.atomic    = query_offset;
      st_next.trusted   = 1'b1;
    end

    // external leap notice only counts with followed sources
    if (ext_leap_pending && follow_src) begin
      st_next.leap_pend = 1'b1;
      st_next.leap_pos  = ext_leap_positive;
    end

    // bus data phase: writes land here, after any hardware clear, so sets win
    if (st_reg.ap_wr) begin
      if (st_reg.ap_addr == ADDR_CTRL) begin
        st_next.mode     = tdap_mode_t'(wd[CTRL_MODE_LSB +: 2]);
        if (tdap_mode_t'(wd[CTRL_MODE_LSB +: 2]) == SEAS_DISABLED) begin
          st_next.seas_min    = '0;
          st_next.seas_active = 1'b0;
        end
        st_next.defer    = wd[CTRL_DEFER];
        st_next.qrestart = wd[CTRL_QRESTART];
        st_next.announce = wd[CTRL_ANNOUNCE];
        st_next.alarm_en = wd[CTRL_ALARM_EN];
        st_next.src      = tdap_src_t'(wd[CTRL_SRC_LSB +: 2]);
        if (wd[CTRL_LEAP_SET]) begin
          st_next.leap_pend = 1'b1;
          st_next.leap_pos  = wd[CTRL_LEAP_POS];
        end
        if (wd[CTRL_QUERY] && manual_src) st_next.query_req = 1'b1;
      end else if (st_reg.ap_addr == ADDR_SEAS_OFS) begin
        st_next.seas_ofs_w = wd & MASK_OFS;
      end else if (st_reg.ap_addr == ADDR_ONCE) begin
        st_next.once_w = wd & MASK_ONCE;
      end else if (st_reg.ap_addr == ADDR_REC_START) begin
        st_next.rstart_w = wd & MASK_RULE;
      end else if (st_reg.ap_addr == ADDR_REC_END) begin
        st_next.rend_w = wd & MASK_RULE;
      end else if (st_reg.ap_addr == ADDR_LEAP_TIME) begin
        st_next.leap_w = wd & MASK_HM;
      end else if (st_reg.ap_addr == ADDR_ATOMIC_OFS) begin
        if (manual_src) begin
          st_next.atomic  = wd[7:0];
          st_next.trusted = 1'b1;
        end
      end else if (st_reg.ap_addr == ADDR_PROG_PRE) begin
        st_next.pre_w = wd & MASK_HMS;
      end else if (st_reg.ap_addr == ADDR_PROG_ALARM) begin
        st_next.alarm_w = wd & MASK_HMS;
      end else if (st_reg.ap_addr == ADDR_UTC_TIME) begin
        st_next.uh = wd[F_HOUR_LSB +: 5];
        st_next.um = wd[F_MIN_LSB +: 6];
        st_next.us = wd[F_SEC_LSB +: 6];
      end else if (st_reg.ap_addr == ADDR_ZONE_OFS) begin
        st_next.zone_w = wd & MASK_OFS;
      end
    end

    // read mux; reads take one wait state so a preceding write is seen
    if (st_reg.ap_addr == ADDR_CTRL) begin
      rd[CTRL_MODE_LSB +: 2] = st_reg.mode;
      rd[CTRL_DEFER]         = st_reg.defer;
      rd[CTRL_LEAP_POS]      = st_reg.leap_pos;
      rd[CTRL_QRESTART]      = st_reg.qrestart;
      rd[CTRL_ANNOUNCE]      = st_reg.announce;
      rd[CTRL_ALARM_EN]      = st_reg.alarm_en;
      rd[CTRL_SRC_LSB +: 2]  = st_reg.src;
    end else if (st_reg.ap_addr == ADDR_SEAS_OFS) begin
      rd = st_reg.seas_ofs_w;
    end else if (st_reg.ap_addr == ADDR_ONCE) begin
      rd = st_reg.once_w;
    end else if (st_reg.ap_addr == ADDR_REC_START) begin
      rd = st_reg.rstart_w;
    end else if (st_reg.ap_addr == ADDR_REC_END) begin
      rd = st_reg.rend_w;
    end else if (st_reg.ap_addr == ADDR_LEAP_TIME) begin
      rd = st_reg.leap_w;
    end else if (st_reg.ap_addr == ADDR_ATOMIC_OFS) begin
      rd[7:0] = st_reg.atomic;
    end else if (st_reg.ap_addr == ADDR_STATUS) begin
      rd[STAT_TRUSTED]    = st_reg.trusted || st_reg.announce;
      rd[STAT_ANNOUNCE]   = st_reg.announce;
      rd[STAT_SEAS_ACT]   = st_reg.seas_active;
      rd[STAT_LEAP_PEND]  = st_reg.leap_pend;
      rd[STAT_LEAP_POS]   = st_reg.leap_pos;
      rd[STAT_LEAP_ARMED] = st_reg.leap_armed;
      rd[STAT_QUERY_REQ]  = st_reg.query_req;
      rd[STAT_ALARM]      = st_reg.gpo_alarm;
    end else if (st_reg.ap_addr == ADDR_PROG_PRE) begin
      rd = st_reg.pre_w;
    end else if (st_reg.ap_addr == ADDR_PROG_ALARM) begin
      rd = st_reg.alarm_w;
    end else if (st_reg.ap_addr == ADDR_PROG_COUNT) begin
      rd[F_HOUR_LSB +: 5] = st_reg.ph;
      rd[F_MIN_LSB +: 6]  = st_reg.pm;
      rd[F_SEC_LSB +: 6]  = st_reg.ps;
    end else if (st_reg.ap_addr == ADDR_UTC_TIME) begin
      rd[F_HOUR_LSB +: 5] = st_reg.uh;
      rd[F_MIN_LSB +: 6]  = st_reg.um;
      rd[F_SEC_LSB +: 6]  = st_reg.us;
    end else if (st_reg.ap_addr == ADDR_ZONE_OFS) begin
      rd = st_reg.zone_w;
    end

    // address phase
    st_next.ap_wr   = 1'b0;
    st_next.rd_pend = 1'b0;
    if (st_reg.rd_pend) begin
      st_next.hrdata = rd;
    end else if (hsel && htrans[1] && hready) begin
      st_next.ap_addr = {haddr[7:2], 2'b00};
      st_next.ap_wr   = hwrite;
      st_next.rd_pend = !hwrite;
      st_next.hreadyout = hwrite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg           <= '0;
      st_reg.hreadyout <= 1'b1;
      st_reg.atomic    <= ATOMIC_OFS_RST;
      st_reg.trusted   <= 1'b0;
      st_reg.qrestart  <= QRESTART_RESET;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign hreadyout                  = st_reg.hreadyout;
  assign hrdata                     = st_reg.hrdata;
  assign hresp                      = 1'b0;
  assign utc_hms                    = {st_reg.uh, st_reg.um, st_reg.us};
  assign local_minute               = st_reg.local_mod;
  assign prog_hms                   = {st_reg.ph, st_reg.pm, st_reg.ps};
  assign atomic_time_offset_seconds = st_reg.atomic;
  assign ptp_offset_valid           = st_reg.announce;
  assign query_req                  = st_reg.query_req;
  assign log_valid                  = st_reg.log_valid;
  assign log_code                   = st_reg.log_code;
  assign gpo_alarm                  = st_reg.gpo_alarm;

endmodule : tdap_adjust

`default_nettype wire

// [sim/tdap_adjust_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module tdap_adjust_sva
  import tdap_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [16:0] utc_hms,
  input wire logic [7:0]  atomic_time_offset_seconds,
  input wire logic        query_req,
  input wire logic        query_done,
  input wire logic        log_valid,
  input wire logic [2:0]  log_code
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic [5:0] sec      = utc_hms[5:0];
  wire logic [7:0] ofs      = atomic_time_offset_seconds;
  wire logic       leap_log = log_valid && log_code == LOG_LEAP;
  //////////
  read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite && hreadyout
    |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  leap_sixty_a: assert property ($rose(sec == SEC_LEAP) |-> $past(sec) == SEC_LAST)
    else $error("second 60 not after 59");
  leap_roll_a: assert property (sec == SEC_LEAP |=> utc_hms == 17'h0 || sec == SEC_LEAP)
    else $error("second 60 not followed by midnight");
  neg_skip_a: assert property (utc_hms == 17'h0 && $past(utc_hms) == {5'h17, 6'h3b, 6'h3a}
    |-> ##[0:2] leap_log) else $error("skip of 59 without leap event");
  leap_step_a: assert property (leap_log |=> 8'(ofs - $past(ofs, 2)) inside {8'h01, 8'hff})
    else $error("offset not stepped by one at leap");
  log_pulse_a: assert property (log_valid |=> !log_valid || $changed(log_code))
    else $error("same event logged twice");
  log_code_a: assert property (log_valid |-> log_code inside {[LOG_SEAS_START:LOG_ALARM]})
    else $error("bad log code");
  query_hold_a: assert property (query_req && !query_done |=> query_req)
    else $error("query request dropped early");
  query_ack_a: assert property (query_req && query_done |=> !query_req)
    else $error("query request not cleared");
  leap_c: cover property (leap_log);
  query_c: cover property ($fell(query_req));
  read_c: cover property (hsel && htrans[1] && !hwrite);
endmodule : tdap_adjust_sva
bind tdap_adjust tdap_adjust_sva i_sva (.*);
`default_nettype wire

// [sim/tb_tdap_adjust.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_tdap_adjust;
  import tdap_pkg::*;
  logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 1, hwrite = 0, sec_tick = 0, hready, hresp;
  logic ext_leap_pending = 0, ext_leap_positive = 0, prog_reset_api = 0, prog_reset_gpi = 0;
  logic query_done = 0, hreadyout, ptp_offset_valid, query_req, log_valid, gpo_alarm;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2, cal_weekday = 0, log_code;
  logic [3:0]  cal_month = 4'h1;
  logic [4:0]  cal_day = 5'h1, cal_month_days = 5'h1f;
  logic [7:0]  query_offset = 0, atomic_time_offset_seconds, q;
  logic [16:0] utc_hms, prog_hms, pre;
  logic [10:0] local_minute;
  int err_total = 0, check_count = 0, cyc = 0;
  logic [2:0]  seen_log = 3'h0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  tdap_adjust #(.QUERY_DELAY(8)) i_dut (.*);
  //////////
  function automatic logic [16:0] inc(input logic [16:0] t);
    logic [4:0] h;
    logic [5:0] m, s;
    {h, m, s} = t;
    s++;
    if (s == 6'h3c) begin s = 0; m++; end
    if (m == 6'h3c) begin m = 0; h++; end
    return {(h == 5'h18) ? 5'h0 : h, m, s};
  endfunction : inc
  function automatic logic [31:0] hms_reg(input logic [16:0] t);
    return {11'h0, t[16:12], 2'h0, t[11:6], 2'h0, t[5:0]};
  endfunction : hms_reg
  task automatic chk(input logic [31:0] e, g, input string n);
    check_count++;
    if (g !== e) begin err_total++; $display("mismatch %s exp %h got %h", n, e, g); end
  endtask : chk
  // master side: hold address until hready, then data until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (!hready);
    rd = hrdata;
  endtask : bus
  task automatic tick();
    sec_tick <= 1; @(posedge hclk); sec_tick <= 0; repeat (3) @(posedge hclk);
  endtask : tick
  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin err_total++; tally_and_finish(); end
  end
  // log pulses last one cycle, so keep the latest code for later checks
  always @(posedge hclk) if (log_valid) seen_log <= log_code;
  initial begin
    q = 8'($urandom(9));
    q = 8'(30 + $urandom % 10);
    pre = {5'($urandom % 24), 6'h3b, 6'h3b};
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    ext_leap_positive <= 1'($urandom);
    {cal_weekday, cal_day} <= {3'($urandom % 7), 5'($urandom % 28 + 1)};
    @(posedge hclk);
    chk(37, atomic_time_offset_seconds, "atomic_rst");
    repeat (20) if (!query_req) @(posedge hclk);
    chk(1, query_req, "query_req");
    query_done <= 1; query_offset <= q; @(posedge hclk); query_done <= 0;
    bus(0, ADDR_STATUS, 0);
    chk({q, 8'h01}, {atomic_time_offset_seconds, rd[7:0]}, "trust");
    bus(1, ADDR_SEAS_OFS, 32'h0100);
    bus(1, ADDR_UTC_TIME, 32'h000a1400);
    repeat (3) @(posedge hclk);
    chk(620, local_minute, "local_min");
    bus(1, ADDR_ONCE, 32'h010a1500 | cal_day);
    bus(1, ADDR_CTRL, 32'h1);
    bus(1, ADDR_UTC_TIME, 32'h000a143b);
    tick();
    chk(681, local_minute, "once_apply");
    bus(0, ADDR_CTRL, 0);
    chk(LOG_SEAS_START, {rd[1:0], seen_log}, "once_done");
    bus(1, ADDR_CTRL, 0);
    repeat (2) @(posedge hclk);
    chk(621, local_minute, "seas_off");
    cal_month_days <= 5'(cal_day + 3);
    bus(1, ADDR_REC_START, 32'h010a1600 | (((cal_day - 1) / 7 + 1) << 4) | cal_weekday);
    bus(1, ADDR_REC_END, 32'h010b1770 | cal_weekday);
    bus(1, ADDR_CTRL, 32'h2);
    bus(1, ADDR_UTC_TIME, 32'h000a153b);
    tick();
    chk(682, local_minute, "rec_start");
    bus(1, ADDR_UTC_TIME, 32'h000a163b);
    tick();
    chk(623, local_minute, "rec_end");
    chk(LOG_SEAS_END, seen_log, "rec_log");
    bus(1, ADDR_CTRL, 32'h18); bus(1, ADDR_UTC_TIME, 32'h00173b3a);
    for (int i = 0; i < 3; i++) begin
      tick();
      chk(i < 2 ? {5'h17, 6'h3b, 6'(6'h3b + i)} : 17'h0, utc_hms, "leap_pos");
    end
    chk(q + 1, atomic_time_offset_seconds, "ofs_pos");
    chk(LOG_LEAP, seen_log, "leap_log");
    bus(1, ADDR_CTRL, 32'h10); bus(1, ADDR_UTC_TIME, 32'h00173b3a); tick();
    chk(0, utc_hms, "leap_neg");
    bus(0, ADDR_STATUS, 0);
    chk({q, 1'b0}, {atomic_time_offset_seconds, rd[3]}, "leap_clr");
    bus(1, ADDR_PROG_PRE, hms_reg(pre)); bus(1, ADDR_PROG_ALARM, hms_reg(inc(pre)));
    bus(1, ADDR_CTRL, 32'h180); repeat (2) @(posedge hclk);
    chk(pre, prog_hms, "prog_pre");
    tick();
    chk({inc(pre), 1'b1}, {prog_hms, gpo_alarm}, "prog_alarm");
    chk(LOG_ALARM, seen_log, "alarm_log");
    prog_reset_api <= 1; @(posedge hclk); prog_reset_api <= 0; repeat (2) @(posedge hclk);
    chk({pre, 1'b0}, {prog_hms, gpo_alarm}, "prog_api");
    tick();
    prog_reset_gpi <= 1;
    repeat (4) @(posedge hclk);
    prog_reset_gpi <= 0;
    chk(pre, prog_hms, "prog_gpi");
    bus(0, ADDR_PROG_COUNT, 0);
    chk(hms_reg(pre), rd, "prog_reg");
    bus(0, 8'h40, 0);
    chk(0, rd, "unmapped");
    bus(1, ADDR_CTRL, 32'h440);
    bus(1, ADDR_ATOMIC_OFS, 32'h55);
    bus(0, ADDR_STATUS, 0);
    chk(3'b110, {ptp_offset_valid, rd[1], hresp}, "announce");
    chk(q, atomic_time_offset_seconds, "src_guard");
    tally_and_finish();
  end
endmodule : tb_tdap_adjust
`default_nettype wire
